// ==== rtg_pkg.sv ====
// ****************************************************************
// Rate timer package
// ****************************************************************
package rtg_pkg;

   // Bus and datapath widths
   localparam int RTG_ADDR_W = 8;
   localparam int RTG_DIV_W = 16;
   localparam int RTG_PRE_W = 6;
   localparam int RTG_GAP_W = 24;

   // Register byte offsets
   localparam logic [7:0] RTG_OFS_TXC = 8'h00;
   localparam logic [7:0] RTG_OFS_RXC = 8'h04;
   localparam logic [7:0] RTG_OFS_RATEC = 8'h08;
   localparam logic [7:0] RTG_OFS_DIVL = 8'h0C;
   localparam logic [7:0] RTG_OFS_DIVH = 8'h10;
   localparam logic [7:0] RTG_OFS_STAT = 8'h14;

   // Field positions
   localparam int RTG_SYNC_BIT = 4;
   localparam int RTG_HS_BIT = 2;
   localparam int RTG_PEN_BIT = 7;
   localparam int RTG_IDLE_BIT = 6;
   localparam int RTG_WIDE_BIT = 3;

   // Reset values
   localparam logic [7:0] RTG_RST_TXC = 8'h00;
   localparam logic [7:0] RTG_RST_RXC = 8'h00;
   localparam logic [7:0] RTG_RST_RATEC = 8'h00;
   localparam logic [7:0] RTG_RST_DIV = 8'h00;

   // Prescale limits, one less than the multiplier
   localparam logic [5:0] RTG_LIM_X64 = 6'h3F;
   localparam logic [5:0] RTG_LIM_X16 = 6'h0F;
   localparam logic [5:0] RTG_LIM_X4 = 6'h03;

endpackage

// ==== rtg_timer_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Control and tick link between register file and rate timer
// ****************************************************************
interface rtg_timer_if;
   logic enable;
   logic sync;
   logic wide;
   logic high_speed;
   logic clear;
   logic [15:0] divisor;
   logic tick;
   logic [15:0] count;
   logic [5:0] limit;

   modport ctrl (output enable, sync, wide, high_speed, clear, divisor,
                 input tick, count, limit);
   modport timer (input enable, sync, wide, high_speed, clear, divisor,
                  output tick, count, limit);
endinterface
`default_nettype wire

// ==== rtg_rate_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Free-running rate timer: prescaler times divisor counter
// ****************************************************************
module rtg_rate_timer (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Control and tick
   rtg_timer_if.timer ifc
);
   import rtg_pkg::*;

   logic [RTG_PRE_W-1:0] pre_r, pre_nxt, lim;
   logic [RTG_DIV_W-1:0] cnt_r, cnt_nxt, n;
   logic tick_r, tick_nxt;

   // Multiplier choice; high speed is ignored in sync mode
   always_comb begin
      if (ifc.sync)
         lim = RTG_LIM_X4;
      else if (!ifc.wide)
         lim = ifc.high_speed ? RTG_LIM_X16 : RTG_LIM_X64;
      else
         lim = ifc.high_speed ? RTG_LIM_X4 : RTG_LIM_X16;
   end

   // Narrow mode uses the low divisor byte only
   assign n = ifc.wide ? ifc.divisor : {8'h00, ifc.divisor[7:0]};

   // Count next state; >= guards a divisor that shrank under the count
   always_comb begin
      pre_nxt = pre_r;
      cnt_nxt = cnt_r;
      tick_nxt = 1'b0;
      if (ifc.clear || !ifc.enable) begin
         pre_nxt = '0;
         cnt_nxt = '0;
      end else if (pre_r >= lim) begin
         pre_nxt = '0;
         if (cnt_r >= n) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 16'h0001;
         end
      end else begin
         pre_nxt = pre_r + 6'h01;
      end
      // Narrow timer keeps no high byte, even after a width change
      if (!ifc.wide)
         cnt_nxt[15:8] = 8'h00;
   end

   // Timer registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_r <= '0;
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign ifc.tick = tick_r;
   assign ifc.count = cnt_r;
   assign ifc.limit = lim;

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_clear_restart: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ifc.clear |=> (pre_r == 6'h00 && cnt_r == 16'h0000 && !tick_r))
      else $error("timer not cleared by divisor write");

   chk_narrow_count: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (!ifc.wide && !$past(ifc.wide) && $past(ifc.enable)) |->
      cnt_r[15:8] == 8'h00)
      else $error("narrow timer used the high byte");

endmodule // rtg_rate_timer
`default_nettype wire

// ==== rtg_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Rate timer block with AHB-Lite register slave
// ****************************************************************
module rtg_top (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Shift logic side
   input wire logic receive_idle_flag,
   output logic rate_tick,
   output logic port_enable,
   output logic sync_mode
);
   import rtg_pkg::*;

   rtg_timer_if ifc ();

   // ****************************************************************
   // Bus phase tracking
   // ****************************************************************
   logic acc;
   logic wr_pend_r, wr_pend_nxt;
   logic [RTG_ADDR_W-1:0] addr_r, addr_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic hreadyout_r;
   logic hresp_r;

   // Registers seen by software
   logic [7:0] txc_r, txc_nxt;
   logic [7:0] rxc_r, rxc_nxt;
   logic [7:0] ratec_r, ratec_nxt;
   logic [7:0] divl_r, divl_nxt;
   logic [7:0] divh_r, divh_nxt;
   logic div_wr;

   // Transfer qualified in its address phase; hsize is not decoded
   assign acc = hsel && hready && htrans[1];

   // Address phase capture and write commit in the data phase
   always_comb begin
      wr_pend_nxt = acc && hwrite;
      addr_nxt = acc ? haddr[RTG_ADDR_W-1:0] : addr_r;
      txc_nxt = txc_r;
      rxc_nxt = rxc_r;
      ratec_nxt = ratec_r;
      divl_nxt = divl_r;
      divh_nxt = divh_r;
      if (wr_pend_r) begin
         case (addr_r)
            RTG_OFS_TXC: begin
               txc_nxt = 8'h00;
               txc_nxt[RTG_SYNC_BIT] = hwdata[RTG_SYNC_BIT];
               txc_nxt[RTG_HS_BIT] = hwdata[RTG_HS_BIT];
            end
            RTG_OFS_RXC: begin
               rxc_nxt = 8'h00;
               rxc_nxt[RTG_PEN_BIT] = hwdata[RTG_PEN_BIT];
            end
            RTG_OFS_RATEC: begin
               ratec_nxt = 8'h00;
               ratec_nxt[RTG_WIDE_BIT] = hwdata[RTG_WIDE_BIT];
            end
            RTG_OFS_DIVL: divl_nxt = hwdata[7:0];
            RTG_OFS_DIVH: divh_nxt = hwdata[7:0];
            default: ;
         endcase
      end
   end

   // Either divisor byte restarts the timer in the same edge
   assign div_wr = wr_pend_r &&
      (addr_r == RTG_OFS_DIVL || addr_r == RTG_OFS_DIVH);

   // Read data from next values, so a read right after a write sees it
   always_comb begin
      hrdata_nxt = hrdata_r;
      if (acc && !hwrite) begin
         case (haddr[RTG_ADDR_W-1:0])
            RTG_OFS_TXC: hrdata_nxt = {24'h000000, txc_nxt};
            RTG_OFS_RXC: hrdata_nxt = {24'h000000, rxc_nxt};
            RTG_OFS_RATEC: begin
               hrdata_nxt = {24'h000000, ratec_nxt};
               hrdata_nxt[RTG_IDLE_BIT] = receive_idle_flag;
            end
            RTG_OFS_DIVL: hrdata_nxt = {24'h000000, divl_nxt};
            RTG_OFS_DIVH: hrdata_nxt = {24'h000000, divh_nxt};
            RTG_OFS_STAT: hrdata_nxt = {16'h0000, ifc.count};
            default: hrdata_nxt = 32'h00000000;
         endcase
      end
   end

   // Bus and register flops; zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         addr_r <= '0;
         hrdata_r <= 32'h00000000;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
         txc_r <= RTG_RST_TXC;
         rxc_r <= RTG_RST_RXC;
         ratec_r <= RTG_RST_RATEC;
         divl_r <= RTG_RST_DIV;
         divh_r <= RTG_RST_DIV;
      end else begin
         wr_pend_r <= wr_pend_nxt;
         addr_r <= addr_nxt;
         hrdata_r <= hrdata_nxt;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
         txc_r <= txc_nxt;
         rxc_r <= rxc_nxt;
         ratec_r <= ratec_nxt;
         divl_r <= divl_nxt;
         divh_r <= divh_nxt;
      end
   end

   // ****************************************************************
   // Timer hookup
   // ****************************************************************
   // Control fields steer the timer straight from their flops
   assign ifc.enable = rxc_r[RTG_PEN_BIT];
   assign ifc.sync = txc_r[RTG_SYNC_BIT];
   assign ifc.high_speed = txc_r[RTG_HS_BIT];
   assign ifc.wide = ratec_r[RTG_WIDE_BIT];
   assign ifc.divisor = {divh_r, divl_r};
   assign ifc.clear = div_wr;

   rtg_rate_timer u_timer (
      .hclk (hclk),
      .hresetn (hresetn),
      .ifc (ifc.timer)
   );

   // Outputs, each a flop
   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;
   assign rate_tick = ifc.tick;
   assign port_enable = rxc_r[RTG_PEN_BIT];
   assign sync_mode = txc_r[RTG_SYNC_BIT];

   // ****************************************************************
   // Checks
   // ****************************************************************
   // Helper: cycles since last tick, valid only under stable settings
   logic [RTG_GAP_W-1:0] gap_r, gap_nxt, period;
   logic gap_ok_r, gap_ok_nxt;
   logic [27:0] cfg_r, cfg_nxt;

   assign cfg_nxt = {ifc.enable, ifc.sync, ifc.wide, ifc.high_speed,
                     ifc.divisor, 8'h00};
   assign period = RTG_GAP_W'((ifc.limit + 7'h01) *
      (ifc.wide ? ({1'b0, ifc.divisor} + 17'h00001)
                : {9'h000, ifc.divisor[7:0]} + 17'h00001));

   always_comb begin
      gap_nxt = rate_tick ? 24'h000001 : gap_r + 24'h000001;
      gap_ok_nxt = gap_ok_r || rate_tick;
      if (ifc.clear || !ifc.enable || cfg_nxt != cfg_r)
         gap_ok_nxt = 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap_r <= 24'h000000;
         gap_ok_r <= 1'b0;
         cfg_r <= 28'h0000000;
      end else begin
         gap_r <= gap_nxt;
         gap_ok_r <= gap_ok_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   // Tick spacing, checked only under settled settings
   chk_tick_period: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (rate_tick && gap_ok_r && cfg_nxt == cfg_r) |-> gap_r == period)
      else $error("tick spacing differs from multiplier times n+1");

   // Multiplier per mode; the two async high speed rows of the divide table share one check
   chk_sync_mult: assert property (
      @(posedge hclk) disable iff (!hresetn)
      sync_mode |-> ifc.limit == 6'h03)
      else $error("sync mode not dividing by 4");

   chk_async_low8: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (!sync_mode && !ifc.wide && !ifc.high_speed) |->
      ifc.limit == 6'h3F)
      else $error("async narrow low speed not dividing by 64");

   chk_async_low16: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (!sync_mode && ifc.wide && !ifc.high_speed) |->
      ifc.limit == 6'h0F)
      else $error("async wide low speed not dividing by 16");

   chk_async_high: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (!sync_mode && ifc.high_speed) |->
      ifc.limit == (ifc.wide ? 6'h03 : 6'h0F))
      else $error("async high speed multiplier wrong");

   // Either divisor byte restarts the timer at the commit edge
   chk_divisor_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (acc && hwrite && haddr[7:0] == RTG_OFS_DIVL) |=>
      ifc.clear ##1 (ifc.count == 16'h0000 && !rate_tick))
      else $error("divisor write did not restart the timer");

   chk_divh_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (acc && hwrite && haddr[7:0] == RTG_OFS_DIVH) |=>
      ifc.clear ##1 (ifc.count == 16'h0000 && !rate_tick))
      else $error("high divisor write did not restart the timer");

   // Disabled port holds the timer at zero
   chk_port_off: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !port_enable [*2] |-> (!rate_tick && ifc.count == 16'h0000))
      else $error("timer ran while port disabled");

   // Control bits follow the write that carried them
   chk_sync_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_r && addr_r == RTG_OFS_TXC) |=>
      sync_mode == $past(hwdata[RTG_SYNC_BIT]))
      else $error("sync select not taken from write");

   chk_speed_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_r && addr_r == RTG_OFS_TXC) |=>
      ifc.high_speed == $past(hwdata[RTG_HS_BIT]))
      else $error("speed select not taken from write");

   chk_wide_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_r && addr_r == RTG_OFS_RATEC) |=>
      ifc.wide == $past(hwdata[RTG_WIDE_BIT]))
      else $error("wide select not taken from write");

   chk_enable_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend_r && addr_r == RTG_OFS_RXC) |=>
      port_enable == $past(hwdata[RTG_PEN_BIT]))
      else $error("port enable not taken from write");

   // Divisor bytes read back as they stand after a same-edge write
   chk_divl_read: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite && haddr[7:0] == RTG_OFS_DIVL) |=>
      hrdata == {24'h000000, divl_r})
      else $error("low divisor byte read back wrong");

   chk_divh_read: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite && haddr[7:0] == RTG_OFS_DIVH) |=>
      hrdata == {24'h000000, divh_r})
      else $error("high divisor byte read back wrong");

   // Idle flag is sampled live at the read, never stored
   chk_idle_mirror: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite && haddr[7:0] == RTG_OFS_RATEC) |=>
      hrdata[RTG_IDLE_BIT] == $past(receive_idle_flag))
      else $error("receive idle flag not mirrored on read");

   // A tick lasts one cycle; the shortest period is four cycles
   chk_tick_pulse: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rate_tick |=> !rate_tick)
      else $error("rate tick stood longer than one cycle");

   // Main scenarios reached
   cov_sync_tick: cover property (@(posedge hclk) disable iff (!hresetn)
      sync_mode && rate_tick && gap_ok_r);
   cov_async_narrow: cover property (@(posedge hclk) disable iff (!hresetn)
      !sync_mode && !ifc.wide && rate_tick && gap_ok_r);
   cov_async_wide: cover property (@(posedge hclk) disable iff (!hresetn)
      !sync_mode && ifc.wide && ifc.high_speed && rate_tick);
   cov_restart: cover property (@(posedge hclk) disable iff (!hresetn)
      ifc.clear && ifc.count != 16'h0000);
   cov_port_off: cover property (@(posedge hclk) disable iff (!hresetn)
      $fell(port_enable));

endmodule // rtg_top
`default_nettype wire

// ==== rtg_shift_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Shift logic stand-in: counts rate ticks, reports receiver state
// ****************************************************************
module rtg_shift_model (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Rate timer side
   input wire logic rate_tick,
   input wire logic port_enable,
   // Bench command: pretend a frame is being received
   input wire logic busy_cmd,
   // Observed state
   output logic receive_idle_flag,
   output logic [15:0] tick_count
);
   logic [15:0] tick_count_nxt;

   // Receiver is idle unless a frame is in flight on an enabled port
   assign receive_idle_flag = ~(busy_cmd & port_enable);

   // Next tick count
   always_comb begin
      tick_count_nxt = tick_count;
      if (rate_tick) begin
         tick_count_nxt = tick_count + 16'h0001;
      end
   end

   // Tick counter, cleared only by hresetn, not by a port disable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_count <= 16'h0000;
      end else begin
         tick_count <= tick_count_nxt;
      end
   end
endmodule // rtg_shift_model
`default_nettype wire

// ==== tb_serial_baud_rate_generator.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_serial_baud_rate_generator;
   import rtg_pkg::*;
   logic hclk, hresetn, hsel, hwrite, busy_cmd;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, rate_tick, port_enable, sync_mode, receive_idle_flag;
   logic hresp;
   logic [15:0] tick_count, t0;
   int n_fail = 0;
   int comparisons = 0;
   int k, p;
   // Mode table: {sync, wide, high speed} and its multiplier
   logic [2:0] cfg [6] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b101, 3'b110};
   int mul [6] = '{64, 16, 16, 4, 4, 4};
   logic [7:0] rofs [6] = '{RTG_OFS_TXC, RTG_OFS_RXC, RTG_OFS_RATEC,
                            RTG_OFS_DIVL, RTG_OFS_DIVH, RTG_OFS_STAT};
   logic [31:0] rrst [6] = '{32'h0, 32'h0, 32'h40, 32'h0, 32'h0, 32'h0};

   rtg_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .receive_idle_flag(receive_idle_flag),
      .rate_tick(rate_tick), .port_enable(port_enable),
      .sync_mode(sync_mode));

   rtg_shift_model far_end (.hclk(hclk), .hresetn(hresetn),
      .rate_tick(rate_tick), .port_enable(port_enable),
      .busy_cmd(busy_cmd), .receive_idle_flag(receive_idle_flag),
      .tick_count(tick_count));

   // Clock, 10 ns period
   always #5 hclk = ~hclk;

   // ****************************************************************
   // Bus and compare tasks
   // ****************************************************************
   // One single AHB-Lite transfer; read data taken at the data edge
   task automatic xfer(input logic is_wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rdv);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= is_wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
      check({31'h0, hresp}, 32'h0);
      hsel <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] dummy;
      xfer(1'b1, a, wd, dummy);
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, seen,
                  exp);
      end
   endtask

   // Cycles from now until the tick is seen, bounded
   task automatic to_tick(output int cnt);
      cnt = 0;
      do begin
         @(posedge hclk);
         #1;
         cnt++;
      end while (rate_tick !== 1'b1 && cnt < 20000);
   endtask

   task automatic final_report;
      if (n_fail == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   // Watchdog: the run needs well under 40000 cycles
   initial begin
      #400000;
      n_fail++;
      final_report();
   end

   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      busy_cmd = 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values, idle receiver mirrored in rate control
      for (int i = 0; i < 6; i++) begin
         xfer(1'b0, rofs[i], 32'h0, rd);
         check(rd, rrst[i]);
      end
      check({31'h0, port_enable}, 32'h0);
      // Only implemented bits stick; unmapped place reads zero
      wr(RTG_OFS_TXC, 32'hFFFFFFFF);
      xfer(1'b0, RTG_OFS_TXC, 32'h0, rd);
      check(rd, 32'h14);
      wr(RTG_OFS_RATEC, 32'hFFFFFFFF);
      xfer(1'b0, RTG_OFS_RATEC, 32'h0, rd);
      check(rd, 32'h48);
      wr(8'h18, 32'hFFFFFFFF);
      xfer(1'b0, 8'h18, 32'h0, rd);
      check(rd, 32'h0);
      wr(RTG_OFS_RXC, 32'hFFFFFFFF);
      #1;
      check({30'h0, port_enable, sync_mode}, 32'h3);
      // Software looks at the receiver state before a rate change
      busy_cmd <= 1'b1;
      xfer(1'b0, RTG_OFS_RATEC, 32'h0, rd);
      check(rd, 32'h08);
      busy_cmd <= 1'b0;
      xfer(1'b0, RTG_OFS_RATEC, 32'h0, rd);
      check(rd, 32'h48);
      // High byte set but ignored in narrow modes
      wr(RTG_OFS_DIVH, 32'h01);
      for (int i = 0; i < 6; i++) begin
         wr(RTG_OFS_TXC, (32'(cfg[i][2]) << RTG_SYNC_BIT) |
                         (32'(cfg[i][0]) << RTG_HS_BIT));
         wr(RTG_OFS_RATEC, 32'(cfg[i][1]) << RTG_WIDE_BIT);
         p = mul[i] * (cfg[i][1] ? 259 : 3);
         wr(RTG_OFS_DIVL, 32'h02);
         to_tick(k);
         check(32'(k), 32'(p));
         to_tick(k);
         check(32'(k), 32'(p));
      end
      // Mid-count write of the high byte restarts the period
      repeat (100) @(posedge hclk);
      wr(RTG_OFS_DIVH, 32'h01);
      to_tick(k);
      check(32'(k), 32'(4 * 259));
      // Disabled port: timer held cleared, no ticks
      wr(RTG_OFS_RXC, 32'h0);
      #1;
      check({31'h0, port_enable}, 32'h0);
      t0 = tick_count;
      xfer(1'b0, RTG_OFS_STAT, 32'h0, rd);
      check(rd, 32'h0);
      repeat (1200) @(posedge hclk);
      check({16'h0, tick_count}, {16'h0, t0});
      final_report();
   end
endmodule // tb_serial_baud_rate_generator
`default_nettype wire
